// ---- design/counter_regs.svh ----
`ifndef COUNTER_REGS_SVH
`define COUNTER_REGS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_PRESET 8'h04
`define OFS_STATUS 8'h08
`define OFS_WRAPS 8'h0C
`define OFS_EVENTS 8'h10
`define OFS_COMPARE 8'h14

// Control fields
`define CTRL_OVR 0
`define CTRL_ENP 1
`define CTRL_ENT 2
`define CTRL_LOAD 3
`define CTRL_RST 3'h0
`define CTRL_MSB 2

// Status fields
`define STAT_CNT_LSB 0
`define STAT_CARRY 4
`define STAT_MODE_LSB 5
`define STAT_CLRPIN 7

// Event bits
`define EVT_WRAP 0
`define EVT_LOAD 1
`define EVT_CLEAR 2
`define EVT_MATCH 3
`define EVT_W 4
`define EVT_RST 4'h0

// Counter values
`define CNT_ZERO 4'h0
`define CNT_MAX 4'hF
`define CNT_STEP 4'h1
`define NIB_MSB 3
`define WRAP_RST 16'h0000
`define WRAP_STEP 16'h0001

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h0000_0000

`endif

// ---- design/counter_pkg.sv ----
package counter_pkg;

   typedef logic [3:0] count_t;

   typedef enum logic [1:0] {
      MODE_CLEAR,
      MODE_LOAD,
      MODE_COUNT,
      MODE_HOLD
   } mode_t;

endpackage : counter_pkg

// ---- design/count_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface count_if;
   logic loadN;
   logic count_enable_parallel;
   logic count_enable_trickle;
   counter_pkg::count_t preset;
   counter_pkg::count_t count;
   logic carry;
   counter_pkg::mode_t mode;

   modport stage (
      input loadN,
      input count_enable_parallel,
      input count_enable_trickle,
      input preset,
      output count,
      output carry,
      output mode
   );

   modport ctl (
      output loadN,
      output count_enable_parallel,
      output count_enable_trickle,
      output preset,
      input count,
      input carry,
      input mode
   );
endinterface : count_if

`default_nettype wire

// ---- design/counter_stage.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "counter_regs.svh"

module counter_stage (
   // Clock and resets
   input wire logic clk,
   input wire logic rst,
   input wire logic clearN,
   // Control and count
   count_if.stage cif
);

   counter_pkg::count_t count_q;
   counter_pkg::count_t count_d;
   counter_pkg::mode_t mode;

   // Clear beats load, load beats the enables
   assign mode = !clearN ? counter_pkg::MODE_CLEAR :
      !cif.loadN ? counter_pkg::MODE_LOAD :
      (cif.count_enable_parallel && cif.count_enable_trickle) ? counter_pkg::MODE_COUNT :
      counter_pkg::MODE_HOLD;

   always_comb
   begin
      count_d = count_q;
      unique case (mode)
         counter_pkg::MODE_CLEAR: count_d = `CNT_ZERO;
         counter_pkg::MODE_LOAD: count_d = cif.preset;
         counter_pkg::MODE_COUNT: count_d = count_q + `CNT_STEP;
         counter_pkg::MODE_HOLD: count_d = count_q;
      endcase
   end

   // One register for all four bits; async clear needs no clock
   always_ff @(posedge clk or negedge clearN)
   begin
      if (!clearN)
         count_q <= `CNT_ZERO;
      else if (rst)
         count_q <= `CNT_ZERO;
      else
         count_q <= count_d;
   end

   assign cif.count = count_q;
   // Trickle enable feeds forward onto the carry
   assign cif.carry = cif.count_enable_trickle && (count_q == `CNT_MAX);
   assign cif.mode = mode;

endmodule : counter_stage

`default_nettype wire

// ---- design/preset_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "counter_regs.svh"

// Contract, with the override bit clear
// - Four count bits sit in one register and change together.
// - Count, hold and preset happen only at the rising clock edge.
// - Load low at an edge takes the preset data, ignoring both enables.
// - Any preset value from 0 to 15 is accepted.
// - Clear low zeroes the count at once, overriding clock, load, enables.
// - Count up only with load high and both enables high.
// - Carry is high while trickle enable is high and count is 15.
// - Trickle enable low forces the carry low even at 15.
// - Enable transitions at any clock level cause no spurious count change.
// - Load and enable changes reach the count only at the next rising edge.
// - Count wraps from 15 to 0.
// - Carry equals trickle enable ANDed with all four count bits.
module preset_counter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Counter pins
   input wire logic asyncClearN,
   input wire logic loadN,
   input wire logic countEnableParallel,
   input wire logic countEnableTrickle,
   input wire logic [3:0] presetData,
   output logic [3:0] countOut,
   output logic rippleCarryOut,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   count_if cif ();

   counter_stage stage (
      .clk(core_clk),
      .rst(rst),
      .clearN(asyncClearN),
      .cif(cif)
   );

   // Write channel holding registers
   logic awHave_q;
   logic awHave_d;
   logic [7:0] awAddr_q;
   logic [7:0] awAddr_d;
   logic wHave_q;
   logic wHave_d;
   logic [31:0] wData_q;
   logic [31:0] wData_d;
   logic [3:0] wStrb_q;
   logic [3:0] wStrb_d;
   logic bValid_q;
   logic bValid_d;
   logic [1:0] bResp_q;
   logic [1:0] bResp_d;

   // Read channel registers
   logic rValid_q;
   logic rValid_d;
   logic [31:0] rData_q;
   logic [31:0] rData_d;
   logic [1:0] rResp_q;
   logic [1:0] rResp_d;

   // Software-visible state
   logic [2:0] ctrl_q;
   logic [2:0] ctrl_d;
   logic swLoad_q;
   logic swLoad_d;
   counter_pkg::count_t preset_q;
   counter_pkg::count_t preset_d;
   counter_pkg::count_t compare_q;
   counter_pkg::count_t compare_d;
   logic [15:0] wraps_q;
   logic [15:0] wraps_d;
   logic [`EVT_W-1:0] events_q;
   logic [`EVT_W-1:0] events_d;

   // Write decode
   logic doWrite;
   logic [7:0] wrWord;
   logic wrLane0;
   logic hitCtrlW;
   logic hitPresetW;
   logic hitStatusW;
   logic hitWrapsW;
   logic hitEventsW;
   logic hitCompareW;
   logic wrMapped;

   assign doWrite = awHave_q && wHave_q && !bValid_q;
   assign wrWord = {awAddr_q[7:2], 2'b00};
   assign wrLane0 = wStrb_q[0];
   assign hitCtrlW = wrWord == `OFS_CTRL;
   assign hitPresetW = wrWord == `OFS_PRESET;
   assign hitStatusW = wrWord == `OFS_STATUS;
   assign hitWrapsW = wrWord == `OFS_WRAPS;
   assign hitEventsW = wrWord == `OFS_EVENTS;
   assign hitCompareW = wrWord == `OFS_COMPARE;
   assign wrMapped = hitCtrlW || hitPresetW || hitStatusW || hitWrapsW
      || hitEventsW || hitCompareW;

   logic wrCtrl;
   logic wrPreset;
   logic wrEvents;
   logic wrCompare;

   assign wrCtrl = doWrite && hitCtrlW && wrLane0;
   assign wrPreset = doWrite && hitPresetW && wrLane0;
   assign wrEvents = doWrite && hitEventsW && wrLane0;
   assign wrCompare = doWrite && hitCompareW && wrLane0;

   // Write data fields
   logic [2:0] wrCtrlBits;
   logic wrLoadBit;
   counter_pkg::count_t wrNibble;
   logic [`EVT_W-1:0] evtClearMask;
   logic [15:0] wrapsNext;

   assign wrCtrlBits = wData_q[`CTRL_MSB:0];
   assign wrLoadBit = wData_q[`CTRL_LOAD];
   assign wrNibble = wData_q[`NIB_MSB:0];
   // Only a write to the event word may clear bits
   assign evtClearMask = wrEvents ? wData_q[`EVT_W-1:0] : `EVT_RST;
   // Sixteen bits roll over silently; software reads the difference
   assign wrapsNext = wraps_q + `WRAP_STEP;

   // Read decode
   logic arTake;
   logic [7:0] rdWord;
   logic hitCtrlR;
   logic hitPresetR;
   logic hitStatusR;
   logic hitWrapsR;
   logic hitEventsR;
   logic hitCompareR;
   logic rdMapped;

   assign arTake = s_axi_arvalid && s_axi_arready;
   assign rdWord = {s_axi_araddr[7:2], 2'b00};
   assign hitCtrlR = rdWord == `OFS_CTRL;
   assign hitPresetR = rdWord == `OFS_PRESET;
   assign hitStatusR = rdWord == `OFS_STATUS;
   assign hitWrapsR = rdWord == `OFS_WRAPS;
   assign hitEventsR = rdWord == `OFS_EVENTS;
   assign hitCompareR = rdWord == `OFS_COMPARE;
   assign rdMapped = hitCtrlR || hitPresetR || hitStatusR || hitWrapsR
      || hitEventsR || hitCompareR;

   // Control source: pins, or registers when override is set
   logic ovr;

   assign ovr = ctrl_q[`CTRL_OVR];
   // A software load pulse wins over a high load pin
   assign cif.loadN = (ovr ? 1'b1 : loadN) && !swLoad_q;
   assign cif.count_enable_parallel = ovr ? ctrl_q[`CTRL_ENP] : countEnableParallel;
   assign cif.count_enable_trickle = ovr ? ctrl_q[`CTRL_ENT] : countEnableTrickle;
   assign cif.preset = (ovr || swLoad_q) ? preset_q : presetData;

   assign countOut = cif.count;
   // Feeds the next stage's trickle enable
   assign rippleCarryOut = cif.carry;

   // Status word
   logic [31:0] statusWord;

   // Clear pin is read on the clock here; a clear shorter than a cycle can slip past
   assign statusWord = {24'h00_0000, !asyncClearN, cif.mode, cif.carry, cif.count};

   // Readable words, zero above each field
   logic [31:0] ctrlWord;
   logic [31:0] presetWord;
   logic [31:0] wrapsWord;
   logic [31:0] eventsWord;
   logic [31:0] compareWord;
   logic [31:0] rdSelect;

   assign ctrlWord = 32'(ctrl_q);
   assign presetWord = 32'(preset_q);
   assign wrapsWord = 32'(wraps_q);
   assign eventsWord = 32'(events_q);
   assign compareWord = 32'(compare_q);
   // Unmapped offsets read as zero alongside the error response
   assign rdSelect = hitCtrlR ? ctrlWord :
      hitPresetR ? presetWord :
      hitStatusR ? statusWord :
      hitWrapsR ? wrapsWord :
      hitEventsR ? eventsWord :
      hitCompareR ? compareWord :
      `DATA_ZERO;

   // Event sources, sampled on the clock
   logic [`EVT_W-1:0] evtSet;

   assign evtSet[`EVT_WRAP] = cif.mode == counter_pkg::MODE_COUNT && cif.count == `CNT_MAX;
   assign evtSet[`EVT_LOAD] = cif.mode == counter_pkg::MODE_LOAD;
   assign evtSet[`EVT_CLEAR] = !asyncClearN;
   assign evtSet[`EVT_MATCH] = cif.count == compare_q;

   always_comb
   begin
      awHave_d = awHave_q;
      awAddr_d = awAddr_q;
      wHave_d = wHave_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bValid_d = bValid_q;
      bResp_d = bResp_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awHave_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wHave_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      if (doWrite)
      begin
         awHave_d = 1'b0;
         wHave_d = 1'b0;
         bValid_d = 1'b1;
         bResp_d = wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bValid_q && s_axi_bready)
         bValid_d = 1'b0;
   end

   always_comb
   begin
      rValid_d = rValid_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      if (arTake)
      begin
         rValid_d = 1'b1;
         rResp_d = rdMapped ? `RESP_OKAY : `RESP_SLVERR;
         rData_d = rdSelect;
      end
      else if (rValid_q && s_axi_rready)
         rValid_d = 1'b0;
   end

   always_comb
   begin
      ctrl_d = wrCtrl ? wrCtrlBits : ctrl_q;
      swLoad_d = wrCtrl && wrLoadBit;
      preset_d = wrPreset ? wrNibble : preset_q;
      compare_d = wrCompare ? wrNibble : compare_q;
      // Wrap tally follows the stage's own wrap condition
      wraps_d = evtSet[`EVT_WRAP] ? wrapsNext : wraps_q;
      // Write one to clear; a same-cycle event wins
      events_d = (events_q & ~evtClearMask) | evtSet;
   end

   // Handshake outputs stay combinational on purpose
   assign s_axi_awready = !awHave_q && !bValid_q;
   assign s_axi_wready = !wHave_q && !bValid_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         bValid_q <= 1'b0;
         rValid_q <= 1'b0;
      end
      else
      begin
         awHave_q <= awHave_d;
         wHave_q <= wHave_d;
         bValid_q <= bValid_d;
         rValid_q <= rValid_d;
      end
   end

   // Payload registers need no reset
   always_ff @(posedge core_clk)
   begin
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bResp_q <= bResp_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ctrl_q <= `CTRL_RST;
         swLoad_q <= 1'b0;
         preset_q <= `CNT_ZERO;
         compare_q <= `CNT_ZERO;
         wraps_q <= `WRAP_RST;
         events_q <= `EVT_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         swLoad_q <= swLoad_d;
         preset_q <= preset_d;
         compare_q <= compare_d;
         wraps_q <= wraps_d;
         events_q <= events_d;
      end
   end

endmodule : preset_counter

`default_nettype wire

// ---- sim/upper_stage.sv ----
`timescale 1ns/1ps
`default_nettype none

module upper_stage (
   // Clock and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clearN,
   // Cascade
   input wire logic loadN,
   input wire logic carryIn,
   output logic [3:0] upperCount
);
   logic [3:0] upper_q;

   // Next stage counts on the lower carry, same clock
   always_ff @(posedge core_clk or negedge clearN)
   begin
      if (!clearN)
         upper_q <= 4'h0;
      else if (rst || !loadN)
         upper_q <= 4'h0;
      else if (carryIn)
         upper_q <= upper_q + 4'h1;
   end

   assign upperCount = upper_q;
endmodule : upper_stage

`default_nettype wire

// ---- sim/preset_counter_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module preset_counter_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Counter pins
   input wire logic asyncClearN,
   input wire logic loadN,
   input wire logic countEnableParallel,
   input wire logic countEnableTrickle,
   input wire logic [3:0] presetData,
   input wire logic [3:0] countOut,
   input wire logic rippleCarryOut,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence loadReq;
      asyncClearN && !loadN;
   endsequence
   sequence countReq;
      asyncClearN && loadN && countEnableParallel && countEnableTrickle;
   endsequence
   sequence holdReq;
      asyncClearN && loadN && !(countEnableParallel && countEnableTrickle);
   endsequence

   // A clear in the next cycle legally overrides every outcome
   preset_load_a: assert property (
      loadReq |=> !asyncClearN || countOut == $past(presetData))
      else $error("load did not take preset");
   count_up_a: assert property (
      countReq |=> !asyncClearN || countOut == $past(countOut) + 4'h1)
      else $error("count did not step by one");
   hold_count_a: assert property (
      holdReq |=> !asyncClearN || $stable(countOut))
      else $error("count moved while inhibited");
   clear_zero_a: assert property (
      !asyncClearN |-> countOut == 4'h0)
      else $error("count not zero under clear");
   carry_and_a: assert property (
      rippleCarryOut == (countEnableTrickle && countOut == 4'hF))
      else $error("carry not enable and full count");
   trickle_gate_a: assert property (
      !countEnableTrickle |-> !rippleCarryOut)
      else $error("carry high without trickle enable");
   write_resp_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_resp_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
endmodule : preset_counter_assertions

bind preset_counter preset_counter_assertions chk (
   .core_clk, .rst, .asyncClearN, .loadN, .countEnableParallel, .countEnableTrickle,
   .presetData, .countOut, .rippleCarryOut, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid
);

`default_nettype wire

// ---- sim/preset_counter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "counter_regs.svh"

module preset_counter_tb;
   typedef struct packed {
      logic ld;
      logic p;
      logic t;
      logic [3:0] d;
      logic [3:0] q;
      logic c;
   } row_t;
   logic core_clk = 1'b0, rst = 1'b1, asyncClearN = 1'b1, loadN = 1'b1;
   logic countEnableParallel = 1'b0, countEnableTrickle = 1'b0;
   logic [3:0] presetData = 4'h0;
   logic [3:0] countOut, upper;
   logic rippleCarryOut, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [31:0] s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int badCount = 0, nTests = 0;
   // Load 12, count through the wrap, inhibit, then loads with odd enables
   row_t rows [12] = '{
      '{1'b0, 1'b1, 1'b1, 4'hC, 4'hC, 1'b0}, '{1'b1, 1'b1, 1'b1, 4'h0, 4'hD, 1'b0},
      '{1'b1, 1'b1, 1'b1, 4'h0, 4'hE, 1'b0}, '{1'b1, 1'b1, 1'b1, 4'h0, 4'hF, 1'b1},
      '{1'b1, 1'b1, 1'b1, 4'h0, 4'h0, 1'b0}, '{1'b1, 1'b1, 1'b1, 4'h0, 4'h1, 1'b0},
      '{1'b1, 1'b1, 1'b1, 4'h0, 4'h2, 1'b0}, '{1'b1, 1'b0, 1'b1, 4'h0, 4'h2, 1'b0},
      '{1'b1, 1'b1, 1'b0, 4'h0, 4'h2, 1'b0}, '{1'b0, 1'b1, 1'b0, 4'hF, 4'hF, 1'b0},
      '{1'b1, 1'b0, 1'b1, 4'h0, 4'hF, 1'b1}, '{1'b0, 1'b1, 1'b1, 4'h5, 4'h5, 1'b0}};

   preset_counter uut (.core_clk, .rst, .asyncClearN, .loadN, .countEnableParallel,
      .countEnableTrickle, .presetData, .countOut, .rippleCarryOut, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   upper_stage upper_i (.core_clk, .rst, .clearN(asyncClearN), .loadN,
      .carryIn(rippleCarryOut), .upperCount(upper));

   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      nTests++;
      if (seen !== exp)
      begin
         badCount++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrapUp;
      $display("checks %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrapUp

   task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (k == 20)
      begin
         badCount++;
         wrapUp();
      end
      // Let an edge pass so a following call never re-drives bready in the same step
      @(posedge core_clk);
   endtask : axWrite

   task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (k == 20)
      begin
         badCount++;
         wrapUp();
      end
      @(posedge core_clk);
   endtask : axRead

   initial
   begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      for (int i = 0; i < 12; i++)
      begin
         loadN <= rows[i].ld;
         countEnableParallel <= rows[i].p;
         countEnableTrickle <= rows[i].t;
         presetData <= rows[i].d;
         @(posedge core_clk);
         #1;
         check(countOut, rows[i].q, "count");
         check(rippleCarryOut, rows[i].c, "carry");
         if (i == 4) check(upper, 4'h1, "upper");
      end
      loadN <= 1'b1;
      #3 check(countOut, 4'h5, "count");
      @(posedge core_clk);
      #1 check(countOut, 4'h6, "count");
      // Enable glitch between edges must not count
      countEnableParallel <= 1'b0;
      #2 countEnableParallel <= 1'b1;
      #2 countEnableParallel <= 1'b0;
      @(posedge core_clk);
      #1 check(countOut, 4'h6, "count");
      asyncClearN <= 1'b0;
      loadN <= 1'b0;
      presetData <= 4'h9;
      #1 check(countOut, 4'h0, "count");
      @(posedge core_clk);
      #1 check(countOut, 4'h0, "count");
      asyncClearN <= 1'b1;
      @(posedge core_clk);
      #1 check(countOut, 4'h9, "count");
      rst <= 1'b1;
      loadN <= 1'b1;
      @(posedge core_clk);
      #1 check(countOut, 4'h0, "count");
      rst <= 1'b0;
      @(posedge core_clk);
      axWrite(`OFS_PRESET, 32'hFFFF_FFF3, rs);
      check(rs, `RESP_OKAY, "bresp");
      axRead(`OFS_PRESET, rd, rs);
      check(rd, 32'h0000_0003, "preset");
      axRead(`OFS_STATUS, rd, rs);
      check(rd[3:0], 4'h0, "status");
      axRead(8'h40, rd, rs);
      check(rs, `RESP_SLVERR, "rresp");
      check(rd, `DATA_ZERO, "rdata");
      axWrite(8'h40, 32'h0000_0001, rs);
      check(rs, `RESP_SLVERR, "bresp");
      axWrite(`OFS_CTRL, 32'h0000_0006, rs);
      axRead(`OFS_CTRL, rd, rs);
      check(rd, 32'h0000_0006, "ctrl");
      // Count equals the reset compare value every cycle, so the set wins over the clear
      axRead(`OFS_EVENTS, rd, rs);
      check(rd, 32'h0000_0008, "events");
      axWrite(`OFS_EVENTS, 32'h0000_0008, rs);
      axRead(`OFS_EVENTS, rd, rs);
      check(rd, 32'h0000_0008, "events");
      axWrite(`OFS_COMPARE, 32'h0000_0005, rs);
      s_axi_wstrb <= 4'h0;
      axWrite(`OFS_COMPARE, 32'h0000_0009, rs);
      check(rs, `RESP_OKAY, "bresp");
      s_axi_wstrb <= 4'hF;
      axRead(`OFS_COMPARE, rd, rs);
      check(rd, 32'h0000_0005, "compare");
      axWrite(`OFS_EVENTS, 32'h0000_000F, rs);
      axRead(`OFS_EVENTS, rd, rs);
      check(rd, 32'h0000_0000, "events");
      // Load 14, count through the wrap, then inhibit
      presetData <= 4'hE;
      loadN <= 1'b0;
      countEnableParallel <= 1'b1;
      @(posedge core_clk);
      loadN <= 1'b1;
      repeat (2) @(posedge core_clk);
      countEnableParallel <= 1'b0;
      #1 check(countOut, 4'h0, "count");
      check(upper, 4'h1, "upper");
      @(posedge core_clk);
      axRead(`OFS_WRAPS, rd, rs);
      check(rd, 32'h0000_0001, "wraps");
      axRead(`OFS_EVENTS, rd, rs);
      check(rd, 32'h0000_0003, "events");
      axRead(`OFS_STATUS, rd, rs);
      check(rd, 32'h0000_0060, "status");
      wrapUp();
   end
endmodule : preset_counter_tb

`default_nettype wire
